// [rtl/spd_wp_pkg.sv]
// Shared types and constants of the block-protection and acknowledge logic.
package spd_wp_pkg;

  // --------------------------------------------------------------------------
  // Array geometry
  // --------------------------------------------------------------------------
  localparam int ARRAY_BYTES = 512;
  localparam int BLOCK_COUNT = 4;
  localparam int PAGE_BUF_BYTES = 16;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [BLOCK_COUNT-1:0] PROT_CLEAR = 4'h0;

  // --------------------------------------------------------------------------
  // Select-code layout and protection sub-commands
  // --------------------------------------------------------------------------
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_RW_BIT = 0;
  localparam logic [2:0] SUB_CLEAR_ALL = 3'h4;

  // --------------------------------------------------------------------------
  // Types and reset value of the control state
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEL = 3'h1,
    ST_ADDR = 3'h3,
    ST_DATA = 3'h2,
    ST_IGNORE = 3'h6
  } state_t;

  typedef enum logic [1:0] {
    CMD_MEM_WR = 2'h0,
    CMD_SET_PROT = 2'h1,
    CMD_CLR_PROT = 2'h2
  } cmd_t;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    state_t st;
    cmd_t cmd;
    logic [1:0] blk;
    logic page;
    logic [3:0] hi;
    logic [3:0] cnt;
    logic [15:0][7:0] pbuf_d;
    logic [15:0] pbuf_v;
    logic armed;
    logic ack;
    logic ack_valid;
    logic commit;
    logic [7:0] rd_data;
  } regs_t;

  localparam regs_t REGS_RESET = '0;

endpackage : spd_wp_pkg

// [rtl/spd_block_write_protect_ack.sv]
// Block write protection, acknowledge decisions and write commit of the SPD EEPROM.
//
// Functional notes
// - Array erased to all ones on delivery.
// - Protected-block write: data byte not acknowledged, no write.
// - Protected block: set refused, clear-all accepted only with hv_on_strap0 high.
// - Unprotected: memory writes acked, write starts; protection set acked only with hv_on_strap0 high.
// - Query acks select only when block unprotected.
// - Three straps give one of eight addresses.
// - Four 128-byte blocks from page and address.
// - Protection bits survive power cycles.
// - Write starts only on stop after data ack.
`timescale 1ns/1ps
`default_nettype none

module spd_block_write_protect_ack #(
  parameter logic [3:0] TYPE_MEM = 4'h5,
  parameter logic [3:0] TYPE_PROT = 4'h3
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nv_erase_n,
  // Strap pins
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic hv_on_strap0,
  // Byte events from the serial front end
  input wire logic bus_start,
  input wire logic bus_stop,
  input wire logic bit_strobe,
  input wire logic byte_strobe,
  input wire logic [7:0] byte_data,
  input wire logic page_sel,
  // Acknowledge decision and write commit
  output logic ack_valid,
  output logic ack,
  output logic write_start,
  output logic [spd_wp_pkg::BLOCK_COUNT-1:0] block_protected,
  // Array read port
  input wire logic [8:0] rd_addr,
  output logic [7:0] rd_data
);
  import spd_wp_pkg::*;

  if (TYPE_MEM == TYPE_PROT)
  begin : g_type_check
    $error("Memory and protection type codes must differ");
  end

  // --------------------------------------------------------------------------
  // Nonvolatile cells
  // --------------------------------------------------------------------------
  // These cells ignore rst_n on purpose: only the factory erase clears the array; prot also clears on a clear-all command.
  logic [7:0] mem [0:ARRAY_BYTES-1];
  logic [BLOCK_COUNT-1:0] prot;
  regs_t s;
  regs_t n;

  always_ff @(posedge clk or negedge nv_erase_n)
  begin
    if (!nv_erase_n)
    begin
      for (int i = 0; i < ARRAY_BYTES; i++)
      begin
        mem[i] <= ERASED_BYTE;
      end
      prot <= PROT_CLEAR;
    end
    else if (s.commit)
    begin
      case (s.cmd)
        CMD_MEM_WR:
        begin
          for (int i = 0; i < PAGE_BUF_BYTES; i++)
          begin
            if (s.pbuf_v[i])
            begin
              mem[{s.page, s.hi, 4'(i)}] <= s.pbuf_d[i];
            end
          end
        end
        CMD_SET_PROT: prot[s.blk] <= 1'b1;
        CMD_CLR_PROT: prot <= PROT_CLEAR;
        default: prot <= prot;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Control state
  // --------------------------------------------------------------------------
  logic [2:0] strap;
  logic hv;
  assign strap = s.sync2[2:0];
  assign hv = s.sync2[3];

  always_comb
  begin
    n = s;
    n.sync1 = {hv_on_strap0, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
    n.sync2 = s.sync1;
    n.ack_valid = 1'b0;
    n.commit = 1'b0;
    n.rd_data = mem[rd_addr];
    // Any bit after an acknowledge slot means the stop is no longer in the tenth slot.
    if (bit_strobe)
    begin
      n.armed = 1'b0;
    end
    if (bus_start)
    begin
      n.st = ST_SEL;
      n.armed = 1'b0;
    end
    else if (bus_stop)
    begin
      n.st = ST_IDLE;
      n.commit = s.armed;
      n.armed = 1'b0;
    end
    else if (byte_strobe)
    begin
      n.ack_valid = (s.st != ST_IDLE);
      n.ack = 1'b0;
      n.st = ST_IGNORE;
      case (s.st)
        ST_SEL:
        begin
          if (byte_data[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_MEM && byte_data[3:1] == strap)
          begin
            n.ack = 1'b1;
            n.cmd = CMD_MEM_WR;
            n.st = byte_data[SEL_RW_BIT] ? ST_IGNORE : ST_ADDR;
          end
          else if (byte_data[SEL_TYPE_MSB:SEL_TYPE_LSB] == TYPE_PROT)
          begin
            n.blk = byte_data[2:1];
            if (byte_data[SEL_RW_BIT])
            begin
              n.ack = !byte_data[3] && !prot[byte_data[2:1]];
            end
            else if (!hv)
            begin
              n.ack = 1'b0;
            end
            else if (byte_data[3:1] == SUB_CLEAR_ALL)
            begin
              n.ack = 1'b1;
              n.cmd = CMD_CLR_PROT;
              n.st = ST_ADDR;
            end
            else if (!byte_data[3] && !prot[byte_data[2:1]])
            begin
              n.ack = 1'b1;
              n.cmd = CMD_SET_PROT;
              n.st = ST_ADDR;
            end
          end
        end
        ST_ADDR:
        begin
          n.ack = 1'b1;
          n.st = ST_DATA;
          if (s.cmd == CMD_MEM_WR)
          begin
            n.blk = {page_sel, byte_data[7]};
            n.page = page_sel;
            n.hi = byte_data[7:4];
            n.cnt = byte_data[3:0];
            n.pbuf_v = '0;
          end
        end
        ST_DATA:
        begin
          if (s.cmd == CMD_MEM_WR && prot[s.blk])
          begin
            n.ack = 1'b0;
            n.armed = 1'b0;
          end
          else
          begin
            n.ack = 1'b1;
            n.armed = 1'b1;
            n.st = ST_DATA;
            if (s.cmd == CMD_MEM_WR)
            begin
              // Past sixteen bytes the counter wraps inside the page buffer.
              n.pbuf_d[s.cnt] = byte_data;
              n.pbuf_v[s.cnt] = 1'b1;
              n.cnt = s.cnt + 4'h1;
            end
          end
        end
        ST_IDLE: n.st = ST_IDLE;
        default: n.ack = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= REGS_RESET;
    end
    else
    begin
      s <= n;
    end
  end

  assign ack_valid = s.ack_valid;
  assign ack = s.ack;
  assign write_start = s.commit;
  assign block_protected = prot;
  assign rd_data = s.rd_data;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !nv_erase_n);

  logic sel_ev;
  assign sel_ev = byte_strobe && !bus_start && !bus_stop && s.st == ST_SEL;

  sequence s_data_acked;
    byte_strobe && !bus_start && !bus_stop && s.st == ST_DATA
      ##1 ack_valid && ack && !bit_strobe && !bus_start;
  endsequence

  sequence s_clean_stop;
    bus_stop && !bus_start && !bit_strobe;
  endsequence

  a_set_refused: assert property (sel_ev && hv && !byte_data[0]
    && byte_data[7:4] == TYPE_PROT && !byte_data[3] && prot[byte_data[2:1]]
    |=> ack_valid && !ack ##1 !write_start) else $error("Set on protected block was acked");
  a_clear_taken: assert property (sel_ev && hv && !byte_data[0]
    && byte_data[7:4] == TYPE_PROT && byte_data[3:1] == SUB_CLEAR_ALL
    |=> ack && s.st == ST_ADDR) else $error("Clear-all select not acked");
  a_query_ack: assert property (sel_ev && byte_data[0] && byte_data[7:4] == TYPE_PROT
    && !byte_data[3] |=> ack_valid && ack == !$past(prot[byte_data[2:1]]))
    else $error("Query select ack does not follow protection");
  a_ignore_nack: assert property (byte_strobe && !bus_start && !bus_stop
    && s.st == ST_IGNORE |=> ack_valid && !ack) else $error("Ignored slot was acked");
  a_prot_data_nack: assert property (byte_strobe && !bus_start && !bus_stop
    && s.st == ST_DATA && s.cmd == CMD_MEM_WR && prot[s.blk]
    |=> !ack && !s.armed ##1 !write_start) else $error("Protected data byte was acked");
  a_stop_commits: assert property (s_data_acked ##1 s_clean_stop |=> write_start)
    else $error("Stop after data ack did not start a write");
  a_commit_cause: assert property (write_start |-> $past(bus_stop) && $past(s.armed))
    else $error("Write started without stop after data ack");
  a_strap_mismatch: assert property (sel_ev && byte_data[7:4] == TYPE_MEM
    && byte_data[3:1] != strap |=> !ack) else $error("Foreign strap address was acked");
  a_set_takes: assert property (write_start && s.cmd == CMD_SET_PROT
    |=> prot[$past(s.blk)]) else $error("Set protection not stored");
  a_prot_stable: assert property (!write_start |=> $stable(prot))
    else $error("Protection changed without a write cycle");

endmodule : spd_block_write_protect_ack

`default_nettype wire

// [verification/spd_host_model.sv]
// Host model that issues byte events towards the protection logic.
`timescale 1ns/1ps
`default_nettype none
module spd_host_model (
  // Clock and answers
  input wire logic clk,
  input wire logic ack_valid,
  input wire logic ack,
  input wire logic write_start,
  // Byte events
  output logic bus_start,
  output logic bus_stop,
  output logic bit_strobe,
  output logic byte_strobe,
  output logic [7:0] byte_data
);
  initial
  begin
    {bus_start, bus_stop, bit_strobe, byte_strobe} = 4'h0;
    byte_data = 8'h00;
  end
  task automatic cond(input logic stop, output logic w);
    @(posedge clk);
    bus_start <= !stop;
    bus_stop <= stop;
    @(posedge clk);
    bus_start <= 1'b0;
    bus_stop <= 1'b0;
    #1;
    w = write_start;
  endtask : cond
  // The idle data lines show the inverse, so a stale byte never looks fresh.
  task automatic put_byte(input logic [7:0] b, output logic a);
    repeat (8)
    begin
      @(posedge clk);
      bit_strobe <= 1'b1;
    end
    @(posedge clk);
    bit_strobe <= 1'b0;
    byte_strobe <= 1'b1;
    byte_data <= b;
    @(posedge clk);
    byte_strobe <= 1'b0;
    byte_data <= ~b;
    #1;
    a = ack_valid ? ack : 1'bx;
  endtask : put_byte
endmodule : spd_host_model
`default_nettype wire

// [verification/tb_spd_block_write_protect_ack.sv]
// Self-checking bench of the block-protection and acknowledge logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_spd_block_write_protect_ack;
  import spd_wp_pkg::*;
  localparam logic [3:0] TM = 4'h5;
  localparam logic [3:0] TP = 4'h3;
  logic clk, rst_n, nv_erase_n, hv, page_sel, ack_valid, ack, write_start;
  logic bus_start, bus_stop, bit_strobe, byte_strobe;
  logic [2:0] strap;
  logic [7:0] byte_data, rd_data, a, d;
  logic [8:0] rd_addr;
  logic [BLOCK_COUNT-1:0] block_protected;
  logic [1:0] n;
  logic [31:0] seed;
  int num_errors, tests_run;
  spd_block_write_protect_ack #(.TYPE_MEM(TM), .TYPE_PROT(TP)) dut (
    .clk(clk), .rst_n(rst_n), .nv_erase_n(nv_erase_n), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .hv_on_strap0(hv),
    .bus_start(bus_start), .bus_stop(bus_stop), .bit_strobe(bit_strobe),
    .byte_strobe(byte_strobe), .byte_data(byte_data), .page_sel(page_sel),
    .ack_valid(ack_valid), .ack(ack), .write_start(write_start),
    .block_protected(block_protected), .rd_addr(rd_addr), .rd_data(rd_data));
  spd_host_model host (.clk(clk), .ack_valid(ack_valid), .ack(ack), .write_start(write_start),
    .bus_start(bus_start), .bus_stop(bus_stop), .bit_strobe(bit_strobe),
    .byte_strobe(byte_strobe), .byte_data(byte_data));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [3:0] bmask(input logic [1:0] b);
    return 4'h1 << b;
  endfunction : bmask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick
  task automatic xact(input logic [7:0] s, input logic [2:0] ea, input logic ew, input logic f);
    logic [2:0] g;
    logic w;
    g = 3'h0;
    host.cond(1'b0, w);
    host.put_byte(s, g[2]);
    host.put_byte(a, g[1]);
    if (f)
      host.put_byte(d, g[0]);
    host.cond(1'b1, w);
    `CHK("acks", ea, g)
    `CHK("write_start", ew, w)
    // Protection and array cells take the commit one edge after the write strobe.
    @(posedge clk);
    #1;
  endtask : xact
  task automatic rd(input logic [8:0] ra, input logic [7:0] e);
    @(posedge clk);
    rd_addr <= ra;
    tick(2);
    #1;
    `CHK("rd_data", e, rd_data)
  endtask : rd
  task automatic end_of_test;
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // The full run needs about a fourteenth of this span.
  initial
  begin
    #1_000_000;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    {rst_n, nv_erase_n, hv, page_sel, strap, rd_addr, a, d} = '0;
    seed = 32'h0000_7084;
    tick(4);
    rst_n <= 1'b1;
    nv_erase_n <= 1'b1;
    tick(4);
    seed = xs(seed);
    rd(seed[8:0], ERASED_BYTE);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      @(posedge clk);
      {strap, page_sel, a, d} <= seed[19:0];
      hv <= 1'b0;
      tick(4);
      n = {page_sel, a[7]};
      xact({TM, strap, 1'b0}, 3'h7, 1'b1, 1'b1);
      rd({page_sel, a}, d);
      xact({TM, ~strap, 1'b0}, 3'h0, 1'b0, 1'b1);
      xact({TM, strap, 1'b0}, 3'h6, 1'b0, 1'b0);
      xact({TP, 1'b0, n, 1'b0}, 3'h0, 1'b0, 1'b1);
      @(posedge clk);
      hv <= 1'b1;
      tick(4);
      xact({TP, 1'b0, n, 1'b0}, 3'h7, 1'b1, 1'b1);
      `CHK("block_protected", bmask(n), block_protected)
      @(posedge clk);
      rst_n <= 1'b0;
      tick(2);
      rst_n <= 1'b1;
      tick(4);
      `CHK("block_protected", bmask(n), block_protected)
      xact({TP, 1'b0, n, 1'b0}, 3'h0, 1'b0, 1'b1);
      d = ~d;
      xact({TM, strap, 1'b0}, 3'h6, 1'b0, 1'b1);
      rd({page_sel, a}, ~d);
      xact({TP, 1'b0, n, 1'b1}, 3'h0, 1'b0, 1'b1);
      xact({TP, 1'b0, n ^ 2'h1, 1'b1}, 3'h4, 1'b0, 1'b1);
      xact({TP, 3'h4, 1'b0}, 3'h7, 1'b1, 1'b1);
      `CHK("block_protected", PROT_CLEAR, block_protected)
    end
    end_of_test();
  end
endmodule : tb_spd_block_write_protect_ack
`default_nettype wire
